// *** buck_cfg_pkg.sv ***
package buck_cfg_pkg;
  // register addresses on the control bus
  localparam logic [7:0] OPERATING_COMMAND_ADDR = 8'h14;
  localparam logic [7:0] MODULE_SETTINGS_ADDR   = 8'h15;
  localparam logic [7:0] LIMITS_CONFIG_ADDR     = 8'h16;
  // reset values
  localparam logic [7:0] OPERATING_COMMAND_RST  = 8'h00;
  localparam logic [7:0] MODULE_SETTINGS_RST    = 8'h80;
  localparam logic [7:0] LIMITS_CONFIG_RST      = 8'h02;
  // operating_command fields
  localparam int PWM_LOW_BIT    = 7;
  localparam int PWM_HIGH_BIT   = 6;
  localparam int RAMP_MODE_BIT  = 5;
  localparam int GATING_BIT     = 0;
  localparam logic [7:0] OPERATING_COMMAND_MASK = 8'he1;
  // module settings field
  localparam int STAGE_COUNT_LSB = 4;
  localparam logic [7:0] MODULE_SETTINGS_MASK = 8'hf0;
  // limits_configuration fields
  localparam int CURRENT_LIMIT_LSB  = 6;
  localparam int HEAT_WARN_LSB      = 4;
  localparam int RESET_IND_BIT      = 1;
  localparam int RESTART_BIT        = 0;
  localparam logic [7:0] LIMITS_CONFIG_MASK = 8'hf3;
  // power stage module codes
  localparam logic [3:0] ONE_STAGE_CODE = 4'h0;
  localparam logic [3:0] TWO_STAGE_CODE = 4'h1;
  localparam logic [3:0] STAGES_ONE     = 4'h1;
  localparam logic [3:0] STAGES_TWO     = 4'h2;
  localparam logic [3:0] STAGES_NINE    = 4'h9;
  // synchroniser depth for pins
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    RUN_OFF,
    RUN_ACTIVE,
    RUN_SHUTDOWN,
    RUN_RESTART
  } run_state_e;
endpackage

// *** buck_mode_limits_config_regs.sv ***
// Behaviour
// R1 - select high: forced PWM bit for high chooses auto (0) or forced PWM (1)
// R2 - select low: forced PWM bit for low chooses auto (0) or forced PWM (1)
// R3 - stage count field bits 7:4: 0000 one, 0001 two, others nine; resets 80h
// R4 - restart bit 0: stay off after thermal shutdown, no self restart
// R5 - restart bit 1: new power-up after shutdown clears, registers kept
// R6 - register reset loads reset indicator 1; host writes 0 to watch next reset
// R7 - heat warning field: 00 83C, 01 94C, 10 105C, 11 116C
// R8 - current limit field bits 7:6: 00 5.2A, 01 5.8A, 10 6.2A, 11 6.8A
// R9 - ramp mode bit: 0 auto during voltage ramp, 1 forced PWM through ramp
// R10 - gating bit: 0 ignores select pin, 1 lets pin switch settings
`timescale 1ns/1ns
module buck_mode_limits_config_regs
  import buck_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST,
  // register port from the control bus slave
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WRITE,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // converter status inputs
  input  wire logic       VOLTAGE_SELECT_INPUT,
  input  wire logic       ENABLE_REQUEST,
  input  wire logic       THERMAL_SHUTDOWN,
  input  wire logic       RAMP_ACTIVE,
  // converter controls
  output logic            FORCED_PWM,
  output logic            SELECT_HIGH,
  output logic      [3:0] POWER_STAGE_COUNT,
  output logic      [1:0] HEAT_WARNING_THRESHOLD,
  output logic      [1:0] INDUCTOR_CURRENT_LIMIT,
  output logic            CONVERTER_ON,
  output logic            POWER_UP_START
);

  typedef struct packed {
    logic [7:0]             operating_command;
    logic [7:0]             module_settings;
    logic [7:0]             limits_config;
    logic                   sel_state;
    logic                   tsd_state;
    run_state_e             run;
    logic [7:0]             rdata;
    logic                   forced_pwm;
    logic                   select_high;
    logic [3:0]             stage_count;
    logic [1:0]             heat_warn;
    logic [1:0]             current_limit;
    logic                   conv_on;
    logic                   power_up;
  } state_s;

  state_s cur;
  state_s next_cur;

  // filtered pin levels
  logic sel_settled;
  logic sel_level;
  logic tsd_settled;
  logic tsd_level;

  level_sync #(
    .STAGES  (SYNC_STAGES)
  ) sel_sync_i (
    .clk     (MCLK),
    .rst     (RST),
    .pin     (VOLTAGE_SELECT_INPUT),
    .settled (sel_settled),
    .level   (sel_level)
  );

  level_sync #(
    .STAGES  (SYNC_STAGES)
  ) tsd_sync_i (
    .clk     (MCLK),
    .rst     (RST),
    .pin     (THERMAL_SHUTDOWN),
    .settled (tsd_settled),
    .level   (tsd_level)
  );

  always_comb begin
    logic [7:0] cmd;
    logic [7:0] lim;
    logic [3:0] code;
    logic       use_pwm;
    next_cur = cur;
    cmd      = cur.operating_command;
    lim      = cur.limits_config;
    code     = cur.module_settings[STAGE_COUNT_LSB +: 4];
    use_pwm  = 1'b0;
    // the select pin only moves the accepted state while gated in
    if (sel_settled) begin
      if (cmd[GATING_BIT]) begin  // [R10]
        next_cur.sel_state = sel_level;
      end
    end
    if (tsd_settled) begin
      next_cur.tsd_state = tsd_level;
    end
    // register writes; registers keep their values across thermal restart
    if (REG_WRITE) begin
      case (REG_ADDR)
        OPERATING_COMMAND_ADDR: begin
          next_cur.operating_command = REG_WDATA & OPERATING_COMMAND_MASK;
        end
        MODULE_SETTINGS_ADDR: begin
          next_cur.module_settings = REG_WDATA & MODULE_SETTINGS_MASK;
        end
        LIMITS_CONFIG_ADDR: begin
          next_cur.limits_config = REG_WDATA & LIMITS_CONFIG_MASK;  // [R6]
        end
        default: begin
        end
      endcase
    end
    // register reads, unmapped addresses return zero
    case (REG_ADDR)
      OPERATING_COMMAND_ADDR: next_cur.rdata = cur.operating_command;
      MODULE_SETTINGS_ADDR:   next_cur.rdata = cur.module_settings;
      LIMITS_CONFIG_ADDR:     next_cur.rdata = cur.limits_config;
      default:                next_cur.rdata = 8'h00;
    endcase
    // operating mode
    if (RAMP_ACTIVE) begin
      use_pwm = cmd[RAMP_MODE_BIT];  // [R9]
    end else if (cur.sel_state) begin
      use_pwm = cmd[PWM_HIGH_BIT];  // [R1]
    end else begin
      use_pwm = cmd[PWM_LOW_BIT];  // [R2]
    end
    next_cur.forced_pwm  = use_pwm;
    next_cur.select_high = cur.sel_state;
    // active power stages
    case (code)
      ONE_STAGE_CODE: next_cur.stage_count = STAGES_ONE;  // [R3]
      TWO_STAGE_CODE: next_cur.stage_count = STAGES_TWO;  // [R3]
      default:        next_cur.stage_count = STAGES_NINE;  // [R3]
    endcase
    next_cur.heat_warn     = lim[HEAT_WARN_LSB +: 2];  // [R7]
    next_cur.current_limit = lim[CURRENT_LIMIT_LSB +: 2];  // [R8]
    // run sequencing around thermal shutdown
    next_cur.power_up = 1'b0;
    case (cur.run)
      RUN_OFF: begin
        if (ENABLE_REQUEST && !cur.tsd_state) begin
          next_cur.run      = RUN_ACTIVE;
          next_cur.power_up = 1'b1;
        end
      end
      RUN_ACTIVE: begin
        if (cur.tsd_state) begin
          next_cur.run = RUN_SHUTDOWN;
        end else if (!ENABLE_REQUEST) begin
          next_cur.run = RUN_OFF;
        end
      end
      RUN_SHUTDOWN: begin
        if (!cur.tsd_state && lim[RESTART_BIT]) begin
          next_cur.run = RUN_RESTART;  // [R5]
        end
      end
      RUN_RESTART: begin
        next_cur.run      = RUN_ACTIVE;  // [R5]
        next_cur.power_up = 1'b1;
      end
      default: begin
        next_cur.run = RUN_OFF;
      end
    endcase
    next_cur.conv_on = (next_cur.run == RUN_ACTIVE);  // [R4]
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cur                   <= '0;
      cur.operating_command <= OPERATING_COMMAND_RST;
      cur.module_settings   <= MODULE_SETTINGS_RST;  // [R3]
      cur.limits_config     <= LIMITS_CONFIG_RST;  // [R6]
      cur.stage_count       <= STAGES_NINE;
      cur.run               <= RUN_OFF;
    end else begin
      cur <= next_cur;
    end
  end

  assign REG_RDATA              = cur.rdata;
  assign FORCED_PWM             = cur.forced_pwm;
  assign SELECT_HIGH            = cur.select_high;
  assign POWER_STAGE_COUNT      = cur.stage_count;
  assign HEAT_WARNING_THRESHOLD = cur.heat_warn;
  assign INDUCTOR_CURRENT_LIMIT = cur.current_limit;
  assign CONVERTER_ON           = cur.conv_on;
  assign POWER_UP_START         = cur.power_up;

endmodule

// pin synchroniser: flop chain, idle low after reset
module level_sync
  import buck_cfg_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw pin in, filtered view out
  input  wire logic pin,
  output logic      settled,
  output logic      level
);

  typedef struct packed {
    logic [STAGES-1:0] chain;
  } sync_s;

  sync_s cur;
  sync_s next_cur;

  always_comb begin
    next_cur       = cur;
    next_cur.chain = {cur.chain[STAGES-2:0], pin};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // a change counts once the last two stages agree
  assign settled = (cur.chain[STAGES-1] == cur.chain[STAGES-2]);
  assign level   = cur.chain[STAGES-1];

endmodule

// *** host_model.sv ***
`timescale 1ns/1ns
module host_model (
  // register port
  input  wire logic       MCLK,
  input  wire logic [7:0] REG_RDATA,
  output logic      [7:0] REG_ADDR,
  output logic            REG_WRITE,
  output logic      [7:0] REG_WDATA
);
  initial {REG_ADDR, REG_WRITE, REG_WDATA} = 17'h0;
  // one byte write, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK);
    {REG_ADDR, REG_WDATA, REG_WRITE} = {a, d, 1'b1};
    @(negedge MCLK);
    {REG_WDATA, REG_WRITE} = {~d, 1'b0};
  endtask
  // read data is registered one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge MCLK);
    REG_ADDR = a;
    @(negedge MCLK);
    d = REG_RDATA;
  endtask
endmodule

// *** buck_mode_limits_config_regs_sva.sv ***
`timescale 1ns/1ns
module cfg_checker
  import buck_cfg_pkg::*;
(
  // watched ports
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_WRITE,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       THERMAL_SHUTDOWN,
  input wire logic [3:0] POWER_STAGE_COUNT,
  input wire logic [1:0] HEAT_WARNING_THRESHOLD,
  input wire logic [1:0] INDUCTOR_CURRENT_LIMIT,
  input wire logic       CONVERTER_ON,
  input wire logic       POWER_UP_START
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic       wl;
  logic       wm;
  logic [3:0] sc;
  assign wl = REG_WRITE && REG_ADDR == LIMITS_CONFIG_ADDR;
  assign wm = REG_WRITE && REG_ADDR == MODULE_SETTINGS_ADDR;
  assign sc = REG_WDATA[7:4] == 4'h0 ? 4'h1 : REG_WDATA[7:4] == 4'h1 ? 4'h2 : 4'h9;
  property p_rdback; wl ##1 (!REG_WRITE && REG_ADDR == LIMITS_CONFIG_ADDR) |=>
    REG_RDATA == ($past(REG_WDATA, 2) & 8'hf3); endproperty
  a_rdback: assert property (p_rdback) else $error("read back");
  property p_limit; wl |-> ##2 INDUCTOR_CURRENT_LIMIT == $past(REG_WDATA[7:6], 2); endproperty
  a_limit: assert property (p_limit) else $error("current limit");
  property p_heat; wl |-> ##2 HEAT_WARNING_THRESHOLD == $past(REG_WDATA[5:4], 2); endproperty
  a_heat: assert property (p_heat) else $error("heat threshold");
  property p_stage; wm |-> ##2 POWER_STAGE_COUNT == $past(sc, 2); endproperty
  a_stage: assert property (p_stage) else $error("stage count");
  property p_rstval; $fell(RST) |-> POWER_STAGE_COUNT == 4'h9 && !CONVERTER_ON; endproperty
  a_rstval: assert property (p_rstval) else $error("reset value");
  property p_pulse; POWER_UP_START |=> !POWER_UP_START; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse");
  property p_on; POWER_UP_START |-> ##[0:1] CONVERTER_ON; endproperty
  a_on: assert property (p_on) else $error("not running");
  property p_tsd; THERMAL_SHUTDOWN [*7] |-> !CONVERTER_ON; endproperty
  a_tsd: assert property (p_tsd) else $error("on in shutdown");
endmodule
bind buck_mode_limits_config_regs cfg_checker cfg_checker_i (.*);

// *** tb_buck_mode_limits_config_regs.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module tb_buck_mode_limits_config_regs
  import buck_cfg_pkg::*;
;
  logic       MCLK = 1'b0, RST = 1'b1, VOLTAGE_SELECT_INPUT = 1'b0, ENABLE_REQUEST = 1'b1;
  logic       THERMAL_SHUTDOWN = 1'b0, RAMP_ACTIVE = 1'b0;
  logic       REG_WRITE, FORCED_PWM, SELECT_HIGH, CONVERTER_ON, POWER_UP_START;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, r, d, m[3];
  logic [3:0] POWER_STAGE_COUNT;
  logic [1:0] HEAT_WARNING_THRESHOLD, INDUCTOR_CURRENT_LIMIT;
  integer     fail_count = 0, cmp_count = 0, cyc = 0, seed = 86980, i, a, starts = 0, s0;
  buck_mode_limits_config_regs buck_mode_limits_config_regs_i (.*);
  host_model host_model_i (.*);
  always #20 MCLK = ~MCLK;
  // count power-up pulses where they are settled
  always @(negedge MCLK) starts += POWER_UP_START;
  always @(posedge MCLK) if (++cyc == 3000) begin
    fail_count++;
    stop_test;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // write and keep the model's masked copy
  task automatic put(input integer ad, input logic [7:0] v);
    logic [7:0] mk[3] = '{8'he1, 8'hf0, 8'hf3};
    host_model_i.wr(ad[7:0], v);
    if (ad >= 8'h14 && ad <= 8'h16) m[ad - 8'h14] = v & mk[ad - 8'h14];
  endtask
  task automatic chk_all;
    for (a = 8'h14; a < 8'h18; a++) begin
      host_model_i.rd(a[7:0], r);
      `CHK(r, a < 8'h17 ? m[a - 8'h14] : 8'h00)
    end
  endtask
  initial begin
    m = '{8'h00, 8'h80, 8'h02};
    repeat (3) @(negedge MCLK);
    RST = 1'b0;
    chk_all;
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      put(8'h14 + ($random(seed) & 3), $random(seed));
      host_model_i.rd(8'h15, r);
      `CHK(POWER_STAGE_COUNT, m[1][7:4] == 0 ? 4'h1 : m[1][7:4] == 1 ? 4'h2 : 4'h9)
      `CHK(HEAT_WARNING_THRESHOLD, m[2][5:4])
      `CHK(INDUCTOR_CURRENT_LIMIT, m[2][7:6])
    end
    chk_all;
    $display("random test done");
    for (i = 0; i < 16; i++) begin
      d = {i[0], i[1], i[0] ^ i[1], 4'h0, 1'b1};
      put(8'h14, d);
      {VOLTAGE_SELECT_INPUT, RAMP_ACTIVE} = {i[2], i[3]};
      repeat (6) @(negedge MCLK);
      `CHK(FORCED_PWM, i[3] ? d[5] : i[2] ? d[6] : d[7])
      `CHK(SELECT_HIGH, i[2])
    end
    put(8'h14, 8'h00);
    VOLTAGE_SELECT_INPUT = 1'b0;
    repeat (6) @(negedge MCLK);
    `CHK(SELECT_HIGH, 1'b1)
    $display("mode test done");
    for (i = 1; i >= 0; i--) begin
      put(8'h16, i[7:0]);
      s0 = starts;
      THERMAL_SHUTDOWN = 1'b1;
      repeat (8) @(negedge MCLK);
      `CHK(CONVERTER_ON, 1'b0)
      THERMAL_SHUTDOWN = 1'b0;
      repeat (10) @(negedge MCLK);
      `CHK(CONVERTER_ON, i[0])
      `CHK(starts - s0, i[0])
    end
    chk_all;
    $display("thermal test done");
    RST = 1'b1;
    @(negedge MCLK);
    RST = 1'b0;
    m = '{8'h00, 8'h80, 8'h02};
    chk_all;
    $display("second reset test done");
    stop_test;
  end
endmodule
